// ==== core/ssi_emu_pkg.sv ====
// Package with register map, field codes and timing constants of the SSI encoder emulator.
package ssi_emu_pkg;
  // Register word offsets (byte addresses on the Avalon-MM bus).
  localparam logic [5:0] OFF_MODE = 6'h00;
  localparam logic [5:0] OFF_TURN_BITS = 6'h04;
  localparam logic [5:0] OFF_INTURN_BITS = 6'h08;
  localparam logic [5:0] OFF_LINK_CFG = 6'h0C;
  localparam logic [5:0] OFF_SYNC_SHIFT = 6'h10;
  localparam logic [5:0] OFF_SYNC_ON = 6'h14;
  localparam logic [5:0] OFF_STATUS = 6'h18;
  localparam logic [5:0] OFF_SOURCE = 6'h1C;
  localparam logic [5:0] OFF_CODE_FMT = 6'h20;
  localparam logic [5:0] OFF_BAUD = 6'h24;
  localparam logic [5:0] OFF_TURN_VAL = 6'h28;
  localparam logic [5:0] OFF_INTURN_VAL = 6'h2C;
  localparam logic [5:0] OFF_ENC_POS = 6'h30;
  localparam logic [5:0] OFF_ACT_POS = 6'h34;
  localparam logic [5:0] OFF_TGT_POS = 6'h38;
  // Field positions inside the link configuration word.
  localparam int BIT_IDLE_LEVEL = 0;
  localparam int BIT_CHANGE_EDGE = 1;
  localparam int BIT_PARITY_ON = 2;
  localparam int BIT_PARITY_SENSE = 3;
  // Reset values.
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [5:0] RST_TURN_BITS = 6'h0C;
  localparam logic [5:0] RST_INTURN_BITS = 6'h14;
  localparam logic [3:0] RST_LINK_CFG = 4'h1;
  localparam logic [2:0] RST_SOURCE = 3'h0;
  localparam logic [1:0] RST_BAUD = 2'h0;
  localparam logic [15:0] RST_SYNC_SHIFT = 16'h0000;
  // Limits of the frame.
  localparam int MAX_POS_BITS = 32;
  localparam int TURN_WRAP_BITS = 12;
  localparam int INTURN_RES_BITS = 20;
  // Source selector codes.
  localparam logic [2:0] SRC_ENC = 3'h0;
  localparam logic [2:0] SRC_NEG = 3'h1;
  localparam logic [2:0] SRC_ACT = 3'h2;
  localparam logic [2:0] SRC_TGT = 3'h3;
  localparam logic [2:0] SRC_LOCK = 3'h4;
  localparam logic [2:0] SRC_RESCALE = 3'h5;
  // Timing.
  localparam int CLK_HZ = 20000000;
  localparam int IDLE_TIMEOUT_NS = 25000;
  localparam int IDLE_TIMEOUT_CYC = (IDLE_TIMEOUT_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int CYC_PER_US = CLK_HZ / 1000000;
  localparam int CTRL_CYCLE_NS = 125000;
  localparam int CTRL_CYCLE_CYC = (CTRL_CYCLE_NS * (CLK_HZ / 1000000)) / 1000;
endpackage

// ==== core/ssi_encoder_emulator.sv ====
// SSI encoder emulator top: Avalon-MM registers, clock slave shifter and control cycle sync.
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
module ssi_encoder_emulator #(
  parameter int IDLE_CYC = ssi_emu_pkg::IDLE_TIMEOUT_CYC,
  parameter int CTRL_CYC = ssi_emu_pkg::CTRL_CYCLE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ssiClk,
  output logic ssiData,
  input wire logic [31:0] encoderPosition,
  input wire logic [31:0] lockCallCounter,
  input wire logic [31:0] rescaledPosition,
  output logic ctrlCycleStart
);
  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [2:0] mode_r;
  logic [5:0] turnBits_r;
  logic [5:0] inTurnBits_r;
  logic [3:0] linkCfg_r;
  logic [15:0] syncShift_r;
  logic [31:0] syncOn_r;
  logic [2:0] source_r;
  logic [1:0] baud_r;
  logic [31:0] actPos_r;
  logic [31:0] tgtPos_r;
  logic syncLocked_r;
  logic ackDone_r;
  logic [31:0] rdMux;
  logic wrStrobe;
  logic [31:0] turnValue;
  logic [31:0] inTurnValue;
  logic [31:0] frameWord;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait state: waitrequest drops in the second cycle of every request.
  assign wrStrobe = avs_write && ackDone_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ackDone_r <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ackDone_r <= (avs_read || avs_write) && !ackDone_r;
      avs_waitrequest <= !((avs_read || avs_write) && !ackDone_r);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_r <= ssi_emu_pkg::RST_MODE;
      turnBits_r <= ssi_emu_pkg::RST_TURN_BITS;
      inTurnBits_r <= ssi_emu_pkg::RST_INTURN_BITS;
      linkCfg_r <= ssi_emu_pkg::RST_LINK_CFG;
      syncShift_r <= ssi_emu_pkg::RST_SYNC_SHIFT;
      syncOn_r <= 32'h00000000;
      source_r <= ssi_emu_pkg::RST_SOURCE;
      baud_r <= ssi_emu_pkg::RST_BAUD;
      actPos_r <= 32'h00000000;
      tgtPos_r <= 32'h00000000;
    end else if (wrStrobe) begin
      case (avs_address)
        ssi_emu_pkg::OFF_MODE: mode_r <= avs_writedata[2:0];
        ssi_emu_pkg::OFF_TURN_BITS: turnBits_r <= avs_writedata[5:0];
        ssi_emu_pkg::OFF_INTURN_BITS: inTurnBits_r <= avs_writedata[5:0];
        ssi_emu_pkg::OFF_LINK_CFG: linkCfg_r <= avs_writedata[3:0];
        ssi_emu_pkg::OFF_SYNC_SHIFT: syncShift_r <= avs_writedata[15:0];
        ssi_emu_pkg::OFF_SYNC_ON: syncOn_r <= avs_writedata;
        ssi_emu_pkg::OFF_SOURCE: source_r <= avs_writedata[2:0];
        ssi_emu_pkg::OFF_BAUD: baud_r <= avs_writedata[1:0];
        ssi_emu_pkg::OFF_ACT_POS: actPos_r <= avs_writedata;
        ssi_emu_pkg::OFF_TGT_POS: tgtPos_r <= avs_writedata;
        default: ;
      endcase
    end
  end

  // Unmapped offsets and write-only-effect fields read zero; code format is fixed binary.
  always_comb begin
    case (avs_address)
      ssi_emu_pkg::OFF_MODE: rdMux = {29'h0, mode_r};
      ssi_emu_pkg::OFF_TURN_BITS: rdMux = {26'h0, turnBits_r};
      ssi_emu_pkg::OFF_INTURN_BITS: rdMux = {26'h0, inTurnBits_r};
      ssi_emu_pkg::OFF_LINK_CFG: rdMux = {28'h0, linkCfg_r};
      ssi_emu_pkg::OFF_SYNC_SHIFT: rdMux = {16'h0, syncShift_r};
      ssi_emu_pkg::OFF_SYNC_ON: rdMux = syncOn_r;
      ssi_emu_pkg::OFF_STATUS: rdMux = {31'h0, syncLocked_r};
      ssi_emu_pkg::OFF_SOURCE: rdMux = {29'h0, source_r};
      ssi_emu_pkg::OFF_CODE_FMT: rdMux = 32'h00000000;
      ssi_emu_pkg::OFF_BAUD: rdMux = {30'h0, baud_r};
      ssi_emu_pkg::OFF_TURN_VAL: rdMux = turnValue;
      ssi_emu_pkg::OFF_INTURN_VAL: rdMux = inTurnValue;
      ssi_emu_pkg::OFF_ENC_POS: rdMux = encoderPosition;
      ssi_emu_pkg::OFF_ACT_POS: rdMux = actPos_r;
      ssi_emu_pkg::OFF_TGT_POS: rdMux = tgtPos_r;
      default: rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ackDone_r) begin
      // Captured in the first, wait-state cycle of the read, so the word stands at the edge where waitrequest is low.
      avs_readdata <= rdMux;
    end
  end

  ssi_frame_builder u_frame (
    .sourceSel(source_r),
    .encoderPosition(encoderPosition),
    .actualPosition(actPos_r),
    .targetPosition(tgtPos_r),
    .lockCallCounter(lockCallCounter),
    .rescaledPosition(rescaledPosition),
    .turnBits(turnBits_r),
    .inTurnBits(inTurnBits_r),
    .turnValue(turnValue),
    .inTurnValue(inTurnValue),
    .frameWord(frameWord)
  );

  // ----------------------------------------------------------------
  // Link clock sampling and edge detection
  // ----------------------------------------------------------------
  logic clkMeta_r;
  logic clkSync_r;
  logic clkPrev_r;
  logic active;
  logic idleLevel;
  logic leadEdge;
  logic trailEdge;
  logic shiftEdge;

  // The flops reset to the default idle level, so no false edge is seen after reset.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clkMeta_r <= 1'b1;
      clkSync_r <= 1'b1;
      clkPrev_r <= 1'b1;
    end else begin
      clkMeta_r <= ssiClk;
      clkSync_r <= clkMeta_r;
      clkPrev_r <= clkSync_r;
    end
  end

  assign active = (mode_r == 3'h1);
  assign idleLevel = linkCfg_r[ssi_emu_pkg::BIT_IDLE_LEVEL];
  assign leadEdge = (clkSync_r != clkPrev_r) && (clkPrev_r == idleLevel);
  assign trailEdge = (clkSync_r != clkPrev_r) && (clkSync_r == idleLevel);
  assign shiftEdge = linkCfg_r[ssi_emu_pkg::BIT_CHANGE_EDGE] ? trailEdge : leadEdge;

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  logic [32:0] shift_r;
  logic [5:0] bitsLeft_r;
  logic inFrame_r;
  logic parity_r;
  logic [15:0] idleCnt_r;
  logic timeout;
  logic parityBit;
  logic parityOn;
  logic lastBit;
  logic nextBit;
  logic [5:0] frameLen;
  logic firstEdge;

  // Parity over all sent position bits; odd sense inverts the even result.
  assign parityBit = (^frameWord) ^ !linkCfg_r[ssi_emu_pkg::BIT_PARITY_SENSE];
  assign parityOn = linkCfg_r[ssi_emu_pkg::BIT_PARITY_ON];
  // The sum is formed at seven bits so that large settings cannot wrap below the limit.
  assign frameLen = ((7'(turnBits_r) + 7'(inTurnBits_r)) > 7'd32) ? 6'd32 : 6'(turnBits_r + inTurnBits_r);
  // The idle counter saturates, so a long pause cannot wrap it back below the timeout.
  assign timeout = (idleCnt_r >= 16'(IDLE_CYC));
  assign firstEdge = active && !inFrame_r && leadEdge;
  // The parity bit has a flop of its own because the shift register fills with zeros behind the data.
  assign lastBit = (bitsLeft_r == 6'h01);
  assign nextBit = (lastBit && parityOn) ? parity_r : shift_r[32];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idleCnt_r <= 16'h0000;
    end else if (clkSync_r != clkPrev_r) begin
      idleCnt_r <= 16'h0000;
    end else if (!timeout) begin
      idleCnt_r <= idleCnt_r + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_r <= 33'h000000000;
      parity_r <= 1'b0;
      bitsLeft_r <= 6'h00;
      inFrame_r <= 1'b0;
      ssiData <= 1'b1;
    end else if (!active || (inFrame_r && timeout)) begin
      inFrame_r <= 1'b0;
      bitsLeft_r <= 6'h00;
      ssiData <= 1'b1;
    end else if (firstEdge) begin
      // Position captured at the first edge stays frozen for the whole frame.
      shift_r <= {frameWord, parityBit};
      parity_r <= parityBit;
      bitsLeft_r <= parityOn ? 6'(frameLen + 6'd1) : frameLen;
      inFrame_r <= 1'b1;
      if (!linkCfg_r[ssi_emu_pkg::BIT_CHANGE_EDGE]) begin
        ssiData <= 1'b0;
      end
    end else if (inFrame_r && shiftEdge) begin
      if (bitsLeft_r != 6'h00) begin
        // After the last position bit only the parity flop is left to send.
        ssiData <= nextBit;
        shift_r <= {shift_r[31:0], 1'b0};
        bitsLeft_r <= bitsLeft_r - 6'h01;
      end else begin
        ssiData <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control cycle and synchronization
  // ----------------------------------------------------------------
  logic [15:0] ctrlCnt_r;
  logic [15:0] shiftCnt_r;
  logic shiftRun_r;
  logic [15:0] shiftTarget;
  logic shiftDue;

  assign shiftTarget = 16'(syncShift_r * 16'(ssi_emu_pkg::CYC_PER_US));
  // A delayed restart due next cycle takes over a free-running start, so no two pulses touch.
  assign shiftDue = shiftRun_r && ((17'(shiftCnt_r) + 17'd1) >= 17'(shiftTarget));

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrlCnt_r <= 16'h0000;
      shiftCnt_r <= 16'h0000;
      shiftRun_r <= 1'b0;
      ctrlCycleStart <= 1'b0;
      syncLocked_r <= 1'b0;
    end else begin
      ctrlCycleStart <= 1'b0;
      if (syncOn_r != 32'h00000000 && firstEdge) begin
        shiftRun_r <= 1'b1;
        shiftCnt_r <= 16'h0000;
        // Locked when the poll lands where the previous alignment put the cycle.
        // The count restarts two cycles plus the shift after an aligning edge, hence the sum.
        syncLocked_r <= (((32'(ctrlCnt_r) + 32'(shiftTarget) + 32'd2) % 32'(CTRL_CYC)) == 32'd0);
      end else if (shiftRun_r && shiftCnt_r >= shiftTarget) begin
        shiftRun_r <= 1'b0;
        ctrlCnt_r <= 16'h0000;
        ctrlCycleStart <= 1'b1;
      end else begin
        shiftCnt_r <= shiftCnt_r + 16'h0001;
        if (ctrlCnt_r >= 16'(CTRL_CYC - 1) && !shiftDue) begin
          ctrlCnt_r <= 16'h0000;
          ctrlCycleStart <= 1'b1;
        end else begin
          ctrlCnt_r <= ctrlCnt_r + 16'h0001;
        end
      end
      if (syncOn_r == 32'h00000000) begin
        syncLocked_r <= 1'b0;
      end
    end
  end
endmodule

// ==== core/ssi_frame_builder.sv ====
// Frame builder: selects the position source and splits it into turn and in-turn parts.
module ssi_frame_builder (
  input wire logic [2:0] sourceSel,
  input wire logic [31:0] encoderPosition,
  input wire logic [31:0] actualPosition,
  input wire logic [31:0] targetPosition,
  input wire logic [31:0] lockCallCounter,
  input wire logic [31:0] rescaledPosition,
  input wire logic [5:0] turnBits,
  input wire logic [5:0] inTurnBits,
  output logic [31:0] turnValue,
  output logic [31:0] inTurnValue,
  output logic [31:0] frameWord
);
  logic [31:0] srcVal;
  logic [31:0] turnMask;
  logic [31:0] inMask;
  logic [31:0] inRaw;
  logic [5:0] tb;
  logic [5:0] ib;

  function automatic logic [31:0] lowMask(input logic [5:0] n);
    lowMask = (n >= 6'd32) ? 32'hFFFFFFFF : ((32'h00000001 << n) - 32'h00000001);
  endfunction

  // Source selection; unknown codes fall back to the plain encoder position.
  always_comb begin
    case (sourceSel)
      ssi_emu_pkg::SRC_ENC: srcVal = encoderPosition;
      ssi_emu_pkg::SRC_NEG: srcVal = 32'h00000000 - encoderPosition;
      ssi_emu_pkg::SRC_ACT: srcVal = actualPosition;
      ssi_emu_pkg::SRC_TGT: srcVal = targetPosition;
      ssi_emu_pkg::SRC_LOCK: srcVal = lockCallCounter;
      ssi_emu_pkg::SRC_RESCALE: srcVal = rescaledPosition;
      default: srcVal = encoderPosition;
    endcase
  end

  // Total is clipped to 32 bits, in-turn bits taking precedence.
  assign ib = (inTurnBits > 6'd32) ? 6'd32 : inTurnBits;
  assign tb = ((7'(turnBits) + 7'(ib)) > 7'd32) ? (6'd32 - ib) : turnBits;
  assign turnMask = lowMask(tb) & lowMask(6'(ssi_emu_pkg::TURN_WRAP_BITS));
  assign inMask = lowMask(6'(ssi_emu_pkg::INTURN_RES_BITS));
  assign inRaw = srcVal & inMask;
  assign turnValue = (srcVal >> ssi_emu_pkg::INTURN_RES_BITS) & turnMask;
  // In-turn field of ib bits, MSB aligned to the internal resolution; surplus LSBs are zero.
  assign inTurnValue = (ib >= 6'(ssi_emu_pkg::INTURN_RES_BITS)) ?
    (inRaw << (ib - 6'(ssi_emu_pkg::INTURN_RES_BITS))) :
    (inRaw >> (6'(ssi_emu_pkg::INTURN_RES_BITS) - ib));
  // Binary coding only: turn part above in-turn part, MSB first, then left aligned.
  assign frameWord = ((turnValue << ib) | (inTurnValue & lowMask(ib))) << (6'd32 - tb - ib);
endmodule

// ==== tb/ssi_clock_master.sv ====
// Model of the controller that clocks frames out of the emulator.
module ssi_clock_master (
  output logic ssiClk,
  input wire logic ssiData
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF_NS = 200;
  initial ssiClk = 1'h1;
  task automatic park(input logic idle);
    // Moving off the system clock edge keeps the level change clear of the sampling edge.
    #25;
    ssiClk = idle;
  endtask
  // Bit i is taken just before edge 2i+1+ph, a full half period after the edge that launched it.
  task automatic runFrame(input int nb, input logic idle, input logic ph, output logic [63:0] cap);
    int p;
    int j;
    p = ph;
    cap = '0;
    ssiClk = idle;
    // Starting mid-cycle keeps the edges clear of the sampling edge of the system clock.
    #25;
    for (j = 0; j < 2 * nb + 2; j++) begin
      if (j > p && (j - 1 - p) % 2 == 0 && (j - 1 - p) / 2 < nb) begin
        cap = {cap[62:0], ssiData};
      end
      ssiClk = ~ssiClk;
      #HALF_NS;
    end
  endtask
endmodule

// ==== tb/ssi_emu_checker.sv ====
// Concurrent checks on the ports of the SSI encoder emulator.
module ssi_emu_checker #(
  parameter int IDLE_CYC = 500,
  parameter int CTRL_CYC = 2500
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic ssiClk,
  input wire logic ssiData,
  input wire logic [31:0] encoderPosition,
  input wire logic [31:0] lockCallCounter,
  input wire logic [31:0] rescaledPosition,
  input wire logic ctrlCycleStart
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic clkSeen_r;
  int clkAge_r;
  int ctrlAge_r;
  // The age saturates so that a long idle link never wraps back into the busy window.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clkSeen_r <= 1'h1;
      clkAge_r <= 100000;
      ctrlAge_r <= 0;
    end else begin
      clkSeen_r <= ssiClk;
      clkAge_r <= (ssiClk != clkSeen_r) ? 0 : ((clkAge_r < 100000) ? clkAge_r + 1 : clkAge_r);
      ctrlAge_r <= ctrlCycleStart ? 0 : ctrlAge_r + 1;
    end
  end
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Bus request not answered after one wait state.");
  wait_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read) || $past(avs_write))
    else $error("Bus answer without a request.");
  wait_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("Bus answer lasted more than one cycle.");
  rdata_hold_a: assert property (!$stable(avs_readdata) |-> $past(avs_read))
    else $error("Read data changed without a read.");
  pulse_single_a: assert property (ctrlCycleStart |=> !ctrlCycleStart)
    else $error("Control cycle start longer than one cycle.");
  pulse_spacing_a: assert property (ctrlAge_r <= 2 * CTRL_CYC + 8)
    else $error("Control cycle start missing.");
  data_quiet_a: assert property ($changed(ssiData) |-> clkAge_r <= 6 || clkAge_r >= IDLE_CYC - 4)
    else $error("Data line changed away from a clock edge.");
  data_idle_a: assert property (clkAge_r > IDLE_CYC + 8 |-> ssiData)
    else $error("Data line not at idle level after timeout.");
  cover property (avs_read && !avs_waitrequest);
  cover property ($fell(ssiData));
  cover property (ctrlCycleStart);
endmodule
bind ssi_encoder_emulator ssi_emu_checker #(.IDLE_CYC(IDLE_CYC), .CTRL_CYC(CTRL_CYC)) chk (
  .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .ssiClk(ssiClk), .ssiData(ssiData),
  .encoderPosition(encoderPosition), .lockCallCounter(lockCallCounter),
  .rescaledPosition(rescaledPosition), .ctrlCycleStart(ctrlCycleStart));

// ==== tb/tb_top.sv ====
// Self-checking bench for the SSI encoder emulator.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int IDLE = 20;
  localparam int CTRL = 40;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ssiClk;
  logic ssiData;
  logic [31:0] encoderPosition = 32'hA5C31E69;
  logic [31:0] lockCallCounter = 32'h0001F00D;
  logic [31:0] rescaledPosition = 32'h7E0F0F31;
  logic ctrlCycleStart;
  int err_count = 0;
  int n_checks = 0;
  always #25 ref_clk = ~ref_clk;
  ssi_encoder_emulator #(.IDLE_CYC(IDLE), .CTRL_CYC(CTRL)) dut (.ref_clk(ref_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ssiClk(ssiClk), .ssiData(ssiData),
    .encoderPosition(encoderPosition), .lockCallCounter(lockCallCounter),
    .rescaledPosition(rescaledPosition), .ctrlCycleStart(ctrlCycleStart));
  ssi_clock_master master (.ssiClk(ssiClk), .ssiData(ssiData));
  // ----------------------------------------
  // Reporting and bus access
  // ----------------------------------------
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_frame(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    logic timedOut;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 40);
    timedOut = (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge ref_clk);
    if (timedOut) begin
      err_count++;
      $display("MISMATCH bus answer expected waitrequest 0 seen 1");
      give_verdict();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    check_word(what, exp, q);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Each frame moves the position on, so every frame must carry a freshly latched value.
  task automatic frame(input int nb, input logic idle, input logic ph, input logic [63:0] exp, input string what);
    logic [63:0] cap;
    master.runFrame(nb, idle, ph, cap);
    @(posedge ref_clk);
    encoderPosition <= encoderPosition + 32'h01234567;
    check_frame(what, exp, cap);
    cycles(IDLE + 10);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [5:0] offs [9] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h1C, 6'h24, 6'h3C};
    logic [31:0] vals [9] = '{32'h0, 32'hC, 32'h14, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 9; i++) begin
      rdchk(offs[i], vals[i], "reset value");
    end
    wr(ssi_emu_pkg::OFF_CODE_FMT, 32'h1);
    rdchk(ssi_emu_pkg::OFF_CODE_FMT, 32'h0, "code format");
    wr(ssi_emu_pkg::OFF_BAUD, 32'h3);
    rdchk(ssi_emu_pkg::OFF_BAUD, 32'h3, "baud code");
    wr(ssi_emu_pkg::OFF_STATUS, 32'h1);
    rdchk(ssi_emu_pkg::OFF_STATUS, 32'h0, "lock status");
    wr(6'h3C, 32'hFFFFFFFF);
    rdchk(6'h3C, 32'h0, "unmapped");
  endtask
  task automatic t_link();
    logic [63:0] e;
    for (int c = 0; c < 4; c++) begin
      wr(ssi_emu_pkg::OFF_LINK_CFG, 32'(c));
      master.park(c[0]);
      cycles(IDLE + 10);
      // Leading-edge data opens with a zero start bit; trailing-edge data starts with the MSB.
      e = c[1] ? {30'h0, encoderPosition, 2'h0} : {30'h0, 1'h0, encoderPosition, 1'h0};
      frame(34, c[0], c[1], e, "link frame");
    end
    wr(ssi_emu_pkg::OFF_LINK_CFG, 32'h1);
    master.park(1'h1);
    cycles(IDLE + 10);
  endtask
  task automatic t_parity();
    logic [27:0] d;
    logic p;
    wr(ssi_emu_pkg::OFF_TURN_BITS, 32'h8);
    for (int s = 0; s < 2; s++) begin
      wr(ssi_emu_pkg::OFF_LINK_CFG, 32'h5 | 32'(s << 3));
      d = encoderPosition[27:0];
      p = s ? ^d : ~^d;
      frame(31, 1'h1, 1'h0, 64'({1'h0, d, p, 1'h0}), "parity frame");
    end
    wr(ssi_emu_pkg::OFF_TURN_BITS, 32'hC);
    wr(ssi_emu_pkg::OFF_LINK_CFG, 32'h1);
  endtask
  task automatic t_sources();
    logic [31:0] v [6];
    wr(ssi_emu_pkg::OFF_ACT_POS, 32'h13579BDF);
    wr(ssi_emu_pkg::OFF_TGT_POS, 32'h2468ACE0);
    for (int s = 0; s < 6; s++) begin
      v = '{encoderPosition, -encoderPosition, 32'h13579BDF, 32'h2468ACE0, lockCallCounter, rescaledPosition};
      wr(ssi_emu_pkg::OFF_SOURCE, 32'(s));
      cycles(2 * CTRL + IDLE);
      rdchk(ssi_emu_pkg::OFF_TURN_VAL, 32'(v[s][31:20]), "turn value");
      rdchk(ssi_emu_pkg::OFF_INTURN_VAL, 32'(v[s][19:0]), "in-turn value");
    end
    wr(ssi_emu_pkg::OFF_SOURCE, 32'h0);
  endtask
  task automatic t_inactive();
    for (int m = 0; m < 3; m += 2) begin
      wr(ssi_emu_pkg::OFF_MODE, 32'(m));
      cycles(IDLE + 10);
      frame(33, 1'h1, 1'h0, 64'h1FFFFFFFF, "inactive frame");
    end
    wr(ssi_emu_pkg::OFF_MODE, 32'h1);
    cycles(IDLE + 10);
  endtask
  task automatic t_sync();
    logic [63:0] cap;
    wr(ssi_emu_pkg::OFF_SYNC_SHIFT, 32'h0);
    wr(ssi_emu_pkg::OFF_SYNC_ON, 32'h1);
    // Polls repeat every twelve control cycles, measured from one frame start to the next.
    for (int k = 0; k < 5; k++) begin
      master.runFrame(33, 1'h1, 1'h0, cap);
      #(12 * CTRL * 50 - 13625);
    end
    @(posedge ref_clk);
    rdchk(ssi_emu_pkg::OFF_STATUS, 32'h1, "locked");
    wr(ssi_emu_pkg::OFF_SYNC_ON, 32'h0);
    rdchk(ssi_emu_pkg::OFF_STATUS, 32'h0, "unlocked");
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    t_regs();
    wr(ssi_emu_pkg::OFF_MODE, 32'h1);
    t_link();
    t_parity();
    t_sources();
    t_inactive();
    t_sync();
    give_verdict();
  end
endmodule
